// ---- hdl/mpc_pkg.sv ----
// package of constants and types for the monitor panel controller
package mpc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned DEBOUNCE_US = 10000;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int unsigned POWER_OFF_MS = 2000;
  localparam int unsigned POWER_OFF_CYC = (CLK_HZ / 1000) * POWER_OFF_MS;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam int unsigned DIM_DB = 20;
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned NUM_BTN = 9;
  localparam int unsigned LVL_W = 8;
  localparam int unsigned METER_W = 16;
  // meter thresholds as peak codes on a 16-bit linear scale
  localparam logic [15:0] THR_M3 = 16'hB53C;
  localparam logic [15:0] THR_M14 = 16'h32F5;
  localparam logic [15:0] THR_M48 = 16'h0105;
  // button indices
  localparam int unsigned BTN_OUT_A = 0;
  localparam int unsigned BTN_SRC = 3;
  localparam int unsigned BTN_ATT = 4;
  localparam int unsigned BTN_MONO = 5;
  localparam int unsigned BTN_MUTE = 6;
  localparam int unsigned BTN_AUX = 7;
  localparam int unsigned BTN_PHANTOM = 8;
  // mix bus one-hot codes
  localparam logic [2:0] MIX_1 = 3'h1;
  localparam logic [2:0] MIX_2 = 3'h2;
  localparam logic [2:0] MIX_3 = 3'h4;
  localparam logic REF_PRO = 1'b0;
  typedef enum logic [1:0]
  {
    PWR_OFF = 2'b00,
    PWR_ON = 2'b01,
    PWR_HOLD = 2'b11
  } mpc_pwr_t;
endpackage : mpc_pkg

// ---- hdl/mpc_btn_if.sv ----
// interface carrying debounced press events from the button conditioner
`timescale 1ns/1ps
`default_nettype none
interface mpc_btn_if #(parameter int unsigned N = 9);
  logic [N-1:0] press;
  logic [N-1:0] level;
  modport src (output press, output level);
  modport dst (input press, input level);
endinterface : mpc_btn_if
`default_nettype wire

// ---- hdl/mpc_debounce.sv ----
// debouncer turning raw buttons into one press event per actuation
`timescale 1ns/1ps
`default_nettype none
module mpc_debounce #(
  parameter int unsigned N = 9,
  parameter int unsigned STABLE_CYC = mpc_pkg::DEBOUNCE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [N-1:0] raw_i,
  mpc_btn_if.src btn
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  initial
  begin
    if (STABLE_CYC < 1)
      $error("debounce count must be at least one");
  end
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_btn
      logic [CW-1:0] cnt_r;
      logic state_r;
      logic press_r;
      wire differs = raw_i[g] != state_r;
      wire settled = cnt_r == CW'(STABLE_CYC - 1);
      // a level must hold steady for the whole window before it counts
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          cnt_r <= '0;
          state_r <= 1'b0;
          press_r <= 1'b0;
        end
        else
        begin
          cnt_r <= (differs && !settled) ? cnt_r + CW'(1) : '0;
          if (differs && settled)
            state_r <= raw_i[g];
          press_r <= differs && settled && raw_i[g]; // R21
        end
      end
      assign btn.press[g] = press_r;
      assign btn.level[g] = state_r;
    end
  endgenerate
endmodule : mpc_debounce
`default_nettype wire

// ---- hdl/mpc_meter.sv ----
// four-lamp level meter decoder
`timescale 1ns/1ps
`default_nettype none
module mpc_meter #(
  parameter int unsigned W = mpc_pkg::METER_W
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] peak_i,
  input wire logic clip_i,
  output logic [3:0] lamps_o
);
  initial
  begin
    if (W != 16)
      $error("meter width must be 16 to match thresholds");
  end
  // lamp order: green, amber -14, amber -3, red
  wire [3:0] lamps_nxt = {clip_i, peak_i >= mpc_pkg::THR_M3,
                          peak_i >= mpc_pkg::THR_M14, peak_i >= mpc_pkg::THR_M48};
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      lamps_o <= 4'h0;
    else
      lamps_o <= lamps_nxt;
  end
endmodule : mpc_meter
`default_nettype wire

// ---- hdl/mpc_top.sv ----
// monitor panel controller top: routing, toggles, level takeover, lamps
// Operation
// R1 - alternate mode drives only the selected line output with the chosen mix
// R2 - independent mode drives all three outputs, each with its own mix
// R3 - alternate: output button makes that output sole active and lights lamp
// R4 - independent: output button picks control target and lights lamp
// R5 - source button cycles mix bus for active or targeted output
// R6 - exactly one mix lamp shows the active or targeted output's mix
// R7 - attenuate button toggles lamp and dims all line outputs by 20 dB
// R8 - mono button toggles mono sum for active or targeted output
// R9 - mute button toggles mute for active or targeted output
// R10 - ungang independent: one stored level per line output
// R11 - stored level holds after target change until the knob moves
// R12 - headphone 1 fixed on mix 1, headphone 2 selectable, own levels; no headphone level is output here
// R13 - aux input toggled by button, routed only into mix 1
// R14 - input meter shows selected pair with red, two amber, green lamps
// R15 - output meter shows the selected line output with the same lamps
// R16 - press powers on; hold over two seconds powers off, lamp dim
// R17 - clock lamp picks source, steady when locked, flashing otherwise
// R18 - line 3/4 reference level selectable, professional after reset
// R19 - phantom button toggles power to inputs 1 and 2 with lamp
// R20 - host supplies mode and gang bits; mode changes need no reset
// R21 - buttons debounced to one press event per actuation
`timescale 1ns/1ps
`default_nettype none
module mpc_top #(
  parameter int unsigned DEBOUNCE_CYC = mpc_pkg::DEBOUNCE_CYC,
  parameter int unsigned POWER_OFF_CYC = mpc_pkg::POWER_OFF_CYC,
  parameter int unsigned FLASH_CYC = mpc_pkg::FLASH_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [8:0] btn_raw_i,
  input wire logic power_btn_i,
  input wire logic indep_mode_i,
  input wire logic level_gang_i,
  input wire logic [7:0] level_knob_i,
  input wire logic [1:0] hp2_mix_sel_i,
  input wire logic ref_consumer_i,
  input wire logic in_pair_sel_i,
  input wire logic [15:0] in_peak_a_i,
  input wire logic in_clip_a_i,
  input wire logic [15:0] in_peak_b_i,
  input wire logic in_clip_b_i,
  input wire logic [47:0] out_peak_i,
  input wire logic [2:0] out_clip_i,
  input wire logic clk_src_spdif_i,
  input wire logic clk_locked_i,
  output logic [2:0] line_en_o,
  output logic [8:0] line_mix_o,
  output logic [2:0] line_mono_o,
  output logic [2:0] line_mute_o,
  output logic [23:0] line_level_o,
  output logic atten_on_o,
  output logic [4:0] atten_db_o,
  output logic [2:0] out_lamp_o,
  output logic [2:0] mix_lamp_o,
  output logic atten_lamp_o,
  output logic mono_lamp_o,
  output logic mute_lamp_o,
  output logic [2:0] hp1_mix_o,
  output logic [2:0] hp2_mix_o,
  output logic aux_to_mix1_o,
  output logic aux_to_host_o,
  output logic aux_lamp_o,
  output logic phantom_on_o,
  output logic phantom_lamp_o,
  output logic ref_consumer_o,
  output logic [3:0] in_meter_o,
  output logic [3:0] out_meter_o,
  output logic power_on_o,
  output logic power_lamp_full_o,
  output logic power_lamp_dim_o,
  output logic spdif_lamp_o,
  output logic int_lamp_o
);
  localparam int unsigned PW = $clog2(POWER_OFF_CYC + 1);
  localparam int unsigned FW = $clog2(FLASH_CYC + 1);
  initial
  begin
    if (POWER_OFF_CYC < 1 || FLASH_CYC < 1)
      $error("timing counts must be at least one");
  end

  // cycle mix code 1 -> 2 -> 3 -> 1
  function automatic logic [2:0] next_mix(input logic [2:0] m);
    next_mix = (m == mpc_pkg::MIX_1) ? mpc_pkg::MIX_2 :
               (m == mpc_pkg::MIX_2) ? mpc_pkg::MIX_3 : mpc_pkg::MIX_1;
  endfunction : next_mix
  mpc_btn_if #(.N(mpc_pkg::NUM_BTN)) btn ();
  mpc_debounce #(.N(mpc_pkg::NUM_BTN), .STABLE_CYC(DEBOUNCE_CYC)) u_deb (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .raw_i(btn_raw_i),
    .btn(btn)
  );
  mpc_btn_if #(.N(1)) pbtn ();
  mpc_debounce #(.N(1), .STABLE_CYC(DEBOUNCE_CYC)) u_pdeb (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .raw_i(power_btn_i),
    .btn(pbtn)
  );
  // panel state
  logic [2:0] sel_r;
  logic [2:0] mix_r [3];
  logic [2:0] mono_r;
  logic [2:0] mute_r;
  logic [7:0] lvl_r [3];
  logic [7:0] knob_last_r;
  logic atten_r;
  logic aux_r;
  logic phantom_r;

  wire [2:0] out_press = btn.press[2:0];
  wire any_out_press = |out_press;
  wire knob_moved = level_knob_i != knob_last_r;
  wire src_press = btn.press[mpc_pkg::BTN_SRC];
  wire mono_press = btn.press[mpc_pkg::BTN_MONO];
  wire mute_press = btn.press[mpc_pkg::BTN_MUTE];
  // mix lamp reflects the selected output in both modes
  wire [2:0] sel_mix = sel_r[0] ? mix_r[0] : sel_r[1] ? mix_r[1] : mix_r[2];
  wire sel_mono = |(mono_r & sel_r);
  wire sel_mute = |(mute_r & sel_r);
  // ganged or alternate: the knob drives every output
  wire gang_all = !indep_mode_i || level_gang_i;
  // output select: a higher-index press in the same cycle loses to the lower index
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sel_r <= 3'h1;
    else if (any_out_press)
      sel_r <= out_press[0] ? 3'h1 : out_press[1] ? 3'h2 : 3'h4; // R3 R4
  end
  // knob tracking: the reference follows the knob every cycle, so a change of target alone moves no level
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      knob_last_r <= 8'h00;
    else
      knob_last_r <= level_knob_i; // R11
  end
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_out
      wire is_sel = sel_r[g];
      // per-output mix, mono, mute and level held whatever the mode
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          mix_r[g] <= mpc_pkg::MIX_1;
          mono_r[g] <= 1'b0;
          mute_r[g] <= 1'b0;
          lvl_r[g] <= 8'h00;
        end
        else
        begin
          if (src_press && is_sel)
            mix_r[g] <= next_mix(mix_r[g]); // R5
          if (mono_press && is_sel)
            mono_r[g] <= !mono_r[g]; // R8
          if (mute_press && is_sel)
            mute_r[g] <= !mute_r[g]; // R9
          if (knob_moved && !any_out_press && (gang_all || is_sel))
            lvl_r[g] <= level_knob_i; // R10 R11
        end
      end
      // alternate: only the selected output runs; independent: all run
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          line_en_o[g] <= 1'b0;
          line_mix_o[3*g +: 3] <= mpc_pkg::MIX_1;
          line_mono_o[g] <= 1'b0;
          line_mute_o[g] <= 1'b0;
          line_level_o[8*g +: 8] <= 8'h00;
        end
        else
        begin
          line_en_o[g] <= power_on_o && (indep_mode_i || is_sel); // R1 R2 R20
          line_mix_o[3*g +: 3] <= mix_r[g]; // R1 R2
          line_mono_o[g] <= mono_r[g];
          line_mute_o[g] <= mute_r[g];
          line_level_o[8*g +: 8] <= lvl_r[g];
        end
      end
    end
  endgenerate
  // global toggles
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      atten_r <= 1'b0;
      aux_r <= 1'b0;
      phantom_r <= 1'b0;
    end
    else
    begin
      if (btn.press[mpc_pkg::BTN_ATT])
        atten_r <= !atten_r; // R7
      if (btn.press[mpc_pkg::BTN_AUX])
        aux_r <= !aux_r; // R13
      if (btn.press[mpc_pkg::BTN_PHANTOM])
        phantom_r <= !phantom_r; // R19
    end
  end

  // power: press turns on, hold past the limit turns off
  mpc_pkg::mpc_pwr_t pwr_r;
  mpc_pkg::mpc_pwr_t pwr_nxt;
  logic [PW-1:0] hold_r;
  wire hold_done = hold_r == PW'(POWER_OFF_CYC);
  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      mpc_pkg::PWR_OFF: if (pbtn.press[0]) pwr_nxt = mpc_pkg::PWR_ON; // R16
      mpc_pkg::PWR_ON: if (pbtn.press[0]) pwr_nxt = mpc_pkg::PWR_HOLD;
      mpc_pkg::PWR_HOLD:
        if (!pbtn.level[0])
          pwr_nxt = mpc_pkg::PWR_ON;
        else if (hold_done)
          pwr_nxt = mpc_pkg::PWR_OFF; // R16
      default: pwr_nxt = mpc_pkg::PWR_OFF;
    endcase
  end
  // hold counter runs only while the button stays down after power-on
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pwr_r <= mpc_pkg::PWR_OFF;
      hold_r <= '0;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      hold_r <= (pwr_r == mpc_pkg::PWR_HOLD && !hold_done) ? hold_r + PW'(1) : '0;
    end
  end

  // flash divider for the clock lamp
  logic [FW-1:0] flash_cnt_r;
  logic flash_r;
  wire flash_tick = flash_cnt_r == FW'(FLASH_CYC - 1);
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flash_cnt_r <= '0;
      flash_r <= 1'b0;
    end
    else
    begin
      flash_cnt_r <= flash_tick ? '0 : flash_cnt_r + FW'(1);
      if (flash_tick)
        flash_r <= !flash_r;
    end
  end
  wire clk_lamp = clk_locked_i || flash_r; // R17

  // meters: input pair chosen by host, output follows the selected output
  wire [15:0] in_peak = in_pair_sel_i ? in_peak_b_i : in_peak_a_i;
  wire in_clip = in_pair_sel_i ? in_clip_b_i : in_clip_a_i;
  wire [15:0] out_peak = sel_r[0] ? out_peak_i[15:0] :
                         sel_r[1] ? out_peak_i[31:16] : out_peak_i[47:32];
  wire out_clip = |(out_clip_i & sel_r);
  mpc_meter u_in_meter (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .peak_i(in_peak),
    .clip_i(in_clip),
    .lamps_o(in_meter_o)
  ); // R14
  mpc_meter u_out_meter (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .peak_i(out_peak),
    .clip_i(out_clip),
    .lamps_o(out_meter_o)
  ); // R15

  // registered lamps and fixed routing
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_lamp_o <= 3'h0;
      mix_lamp_o <= 3'h0;
      atten_lamp_o <= 1'b0;
      atten_on_o <= 1'b0;
      atten_db_o <= 5'h00;
      mono_lamp_o <= 1'b0;
      mute_lamp_o <= 1'b0;
      hp1_mix_o <= mpc_pkg::MIX_1;
      hp2_mix_o <= mpc_pkg::MIX_1;
      aux_to_mix1_o <= 1'b0;
      aux_to_host_o <= 1'b0;
      aux_lamp_o <= 1'b0;
      phantom_on_o <= 1'b0;
      phantom_lamp_o <= 1'b0;
      ref_consumer_o <= mpc_pkg::REF_PRO;
      power_on_o <= 1'b0;
      power_lamp_full_o <= 1'b0;
      power_lamp_dim_o <= 1'b0;
      spdif_lamp_o <= 1'b0;
      int_lamp_o <= 1'b0;
    end
    else
    begin
      out_lamp_o <= sel_r; // R3 R4
      mix_lamp_o <= sel_mix; // R6
      atten_lamp_o <= atten_r; // R7
      atten_on_o <= atten_r; // R7
      atten_db_o <= atten_r ? 5'(mpc_pkg::DIM_DB) : 5'h00; // R7
      mono_lamp_o <= sel_mono; // R8
      mute_lamp_o <= sel_mute; // R9
      hp1_mix_o <= mpc_pkg::MIX_1; // R12
      hp2_mix_o <= (hp2_mix_sel_i == 2'h1) ? mpc_pkg::MIX_2 :
                   (hp2_mix_sel_i == 2'h2) ? mpc_pkg::MIX_3 : mpc_pkg::MIX_1; // R12
      aux_to_mix1_o <= aux_r; // R13
      aux_to_host_o <= 1'b0; // R13
      aux_lamp_o <= aux_r;
      phantom_on_o <= phantom_r; // R19
      phantom_lamp_o <= phantom_r; // R19
      ref_consumer_o <= ref_consumer_i; // R18
      power_on_o <= pwr_nxt != mpc_pkg::PWR_OFF; // R16
      power_lamp_full_o <= pwr_nxt != mpc_pkg::PWR_OFF;
      power_lamp_dim_o <= pwr_nxt == mpc_pkg::PWR_OFF;
      spdif_lamp_o <= clk_src_spdif_i && clk_lamp; // R17
      int_lamp_o <= !clk_src_spdif_i && clk_lamp; // R17
    end
  end
endmodule : mpc_top
`default_nettype wire

// ---- test/mpc_top_asserts.sv ----
// concurrent checks on the monitor panel controller top ports
`timescale 1ns/1ps
`default_nettype none
module mpc_top_asserts (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic indep_mode_i,
  input wire logic ref_consumer_i,
  input wire logic clk_src_spdif_i,
  input wire logic clk_locked_i,
  input wire logic [2:0] line_en_o,
  input wire logic [2:0] out_lamp_o,
  input wire logic [2:0] mix_lamp_o,
  input wire logic atten_on_o,
  input wire logic [4:0] atten_db_o,
  input wire logic atten_lamp_o,
  input wire logic [2:0] hp1_mix_o,
  input wire logic aux_to_host_o,
  input wire logic phantom_on_o,
  input wire logic phantom_lamp_o,
  input wire logic ref_consumer_o,
  input wire logic power_on_o,
  input wire logic power_lamp_full_o,
  input wire logic power_lamp_dim_o,
  input wire logic spdif_lamp_o,
  input wire logic int_lamp_o
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // fixed routings never move
  a_aux_host_off: assert property (aux_to_host_o == 1'b0)
    else $error("aux input reached the host stream");
  a_hp1_fixed: assert property (hp1_mix_o == 3'h1)
    else $error("headphone 1 left mix 1");
  // lamps are one-hot once the first edge after reset has landed
  a_mix_onehot: assert property ($past(rstn_i) |-> $onehot(mix_lamp_o))
    else $error("mix lamps not one-hot");
  a_out_onehot: assert property ($past(rstn_i) |-> $onehot(out_lamp_o))
    else $error("output lamps not one-hot");
  a_dim_amount: assert property (atten_on_o |-> atten_db_o == 5'h14 && atten_lamp_o)
    else $error("dimmer amount or lamp wrong");
  // mode checks allow two edges for the enable register to follow
  a_indep_all: assert property ((indep_mode_i && power_on_o) [*3] |-> line_en_o == 3'h7)
    else $error("independent mode not driving all outputs");
  a_alt_single: assert property ((!indep_mode_i && power_on_o) [*3] |-> line_en_o == out_lamp_o)
    else $error("alternate mode enable differs from selected output");
  // tolerant of one edge of skew between power flag and enables
  a_off_silent: assert property (!power_on_o [*4] |-> $past(line_en_o, 2) == 3'h0)
    else $error("line output active while powered off");
  a_lamp_on: assert property (power_on_o [*2] |-> power_lamp_full_o && !power_lamp_dim_o)
    else $error("power lamp not full while on");
  // sampled reset keeps the release edge out, where the lamps still show reset values
  a_lamp_off: assert property ((rstn_i && !power_on_o) [*2] |->
    power_lamp_dim_o && !power_lamp_full_o)
    else $error("power lamp not dim while off");
  a_ref_follow: assert property ($past(rstn_i) |-> ref_consumer_o == $past(ref_consumer_i))
    else $error("reference level did not follow setting");
  a_phantom_lamp: assert property (phantom_lamp_o == phantom_on_o)
    else $error("phantom lamp disagrees with supply");
  a_lock_steady: assert property ((clk_src_spdif_i && clk_locked_i) [*3] |->
    spdif_lamp_o && !int_lamp_o)
    else $error("locked clock lamp not steady");
endmodule : mpc_top_asserts
bind mpc_top mpc_top_asserts chk_u (.ref_clk_i, .rstn_i, .indep_mode_i, .ref_consumer_i,
  .clk_src_spdif_i, .clk_locked_i, .line_en_o, .out_lamp_o, .mix_lamp_o, .atten_on_o,
  .atten_db_o, .atten_lamp_o, .hp1_mix_o, .aux_to_host_o, .phantom_on_o, .phantom_lamp_o,
  .ref_consumer_o, .power_on_o, .power_lamp_full_o, .power_lamp_dim_o, .spdif_lamp_o,
  .int_lamp_o);
`default_nettype wire

// ---- test/mpc_panel_user.sv ----
// behavioural panel user and host software driving buttons and mode bits
`timescale 1ns/1ps
`default_nettype none
module mpc_panel_user #(
  parameter int DEB = 4
) (
  input wire logic ref_clk_i,
  output logic [8:0] btn_raw_o,
  output logic power_btn_o,
  output logic indep_mode_o,
  output logic level_gang_o
);
  // idle panel and alternate mode at time zero
  initial
  begin
    btn_raw_o = 9'h000;
    power_btn_o = 1'b0;
    indep_mode_o = 1'b0;
    level_gang_o = 1'b0;
  end
  // host changes mode and gang live, never around a reset
  task automatic set_host(input logic ind, input logic gng);
    @(posedge ref_clk_i);
    indep_mode_o <= ind;
    level_gang_o <= gng;
  endtask : set_host
  // index 9 is power; a bounce shorter than the window comes before the hold
  task automatic press(input int idx, input int hold);
    logic [9:0] m;
    m = 10'h001 << idx;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk_i);
      {power_btn_o, btn_raw_o} <= i[1] ? 10'h000 : m;
    end
    @(posedge ref_clk_i);
    {power_btn_o, btn_raw_o} <= m;
    repeat (hold) @(posedge ref_clk_i);
    {power_btn_o, btn_raw_o} <= 10'h000;
    repeat (DEB + 4) @(posedge ref_clk_i);
  endtask : press
endmodule : mpc_panel_user
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the monitor panel controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int DEB = 4;
  localparam int POFF = 20;
  localparam int FL = 8;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [8:0] btn_raw_i;
  logic power_btn_i, indep_mode_i, level_gang_i;
  logic [7:0] level_knob_i = 8'h00;
  logic [1:0] hp2_mix_sel_i = 2'h0;
  logic ref_consumer_i = 1'b0;
  logic in_pair_sel_i = 1'b0;
  logic in_clip_a_i = 1'b0;
  logic in_clip_b_i = 1'b0;
  logic [15:0] in_peak_a_i = 16'h0000;
  logic [15:0] in_peak_b_i = 16'h0000;
  logic [47:0] out_peak_i = 48'h0;
  logic [2:0] out_clip_i = 3'h0;
  logic clk_src_spdif_i = 1'b0;
  logic clk_locked_i = 1'b0;
  logic [2:0] line_en_o, line_mono_o, line_mute_o, out_lamp_o, mix_lamp_o, hp2_mix_o;
  logic [8:0] line_mix_o;
  logic [23:0] line_level_o;
  logic [4:0] atten_db_o;
  logic [3:0] in_meter_o, out_meter_o;
  logic atten_on_o, mono_lamp_o, mute_lamp_o, aux_to_mix1_o, aux_lamp_o, phantom_on_o;
  logic ref_consumer_o, power_on_o, power_lamp_full_o, power_lamp_dim_o;
  logic spdif_lamp_o, int_lamp_o;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  // short counts keep the run brief; expectations use the same values
  mpc_top #(.DEBOUNCE_CYC(DEB), .POWER_OFF_CYC(POFF), .FLASH_CYC(FL)) dut_u (
    .ref_clk_i, .rstn_i, .btn_raw_i, .power_btn_i, .indep_mode_i, .level_gang_i,
    .level_knob_i, .hp2_mix_sel_i, .ref_consumer_i, .in_pair_sel_i, .in_peak_a_i,
    .in_clip_a_i, .in_peak_b_i, .in_clip_b_i, .out_peak_i, .out_clip_i, .clk_src_spdif_i,
    .clk_locked_i, .line_en_o, .line_mix_o, .line_mono_o, .line_mute_o, .line_level_o,
    .atten_on_o, .atten_db_o, .out_lamp_o, .mix_lamp_o, .atten_lamp_o(), .mono_lamp_o,
    .mute_lamp_o, .hp1_mix_o(), .hp2_mix_o, .aux_to_mix1_o, .aux_to_host_o(), .aux_lamp_o,
    .phantom_on_o, .phantom_lamp_o(), .ref_consumer_o, .in_meter_o, .out_meter_o,
    .power_on_o, .power_lamp_full_o, .power_lamp_dim_o, .spdif_lamp_o, .int_lamp_o);
  mpc_panel_user #(.DEB(DEB)) user_u (.ref_clk_i, .btn_raw_o(btn_raw_i),
    .power_btn_o(power_btn_i), .indep_mode_o(indep_mode_i), .level_gang_o(level_gang_i));
  always #10 ref_clk_i = ~ref_clk_i;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // settle past the edge so registered outputs are read after they land
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic pr(input int idx);
    user_u.press(idx, DEB + 4);
    tick(2);
  endtask : pr
  task automatic kn(input logic [7:0] v);
    @(posedge ref_clk_i);
    level_knob_i <= v;
    tick(3);
  endtask : kn
  task automatic t_start();
    chk("ref_out", ref_consumer_o, 1'b0);
    chk("dim_lamp", power_lamp_dim_o, 1'b1);
    chk("line_en", line_en_o, 3'h0);
    @(posedge ref_clk_i);
    ref_consumer_i <= 1'b1;
    tick(2);
    chk("ref_out", ref_consumer_o, 1'b1);
    pr(9);
    chk("power", {power_on_o, power_lamp_full_o}, 2'h3);
    chk("line_en", line_en_o, 3'h1);
    pr(9);
    chk("power", power_on_o, 1'b1);
  endtask : t_start
  task automatic t_alt();
    logic [2:0] em [3];
    em = '{3'h2, 3'h4, 3'h1};
    pr(1);
    chk("out_lamp", out_lamp_o, 3'h2);
    chk("line_en", line_en_o, 3'h2);
    for (int k = 0; k < 3; k++)
    begin
      pr(3);
      chk("mix_b", line_mix_o[5:3], em[k]);
      chk("mix_lamp", mix_lamp_o, em[k]);
    end
  endtask : t_alt
  task automatic t_indep();
    user_u.set_host(1'b1, 1'b0);
    tick(2);
    chk("line_en", line_en_o, 3'h7);
    pr(2);
    chk("target_c", {out_lamp_o, line_en_o}, 6'h27);
    pr(3);
    chk("line_mix", line_mix_o, 9'h089);
    chk("mix_lamp", mix_lamp_o, 3'h2);
    pr(5);
    pr(6);
    chk("mono_mute", {line_mono_o, line_mute_o, mono_lamp_o, mute_lamp_o}, 8'h93);
    pr(0);
    chk("target_a", {mono_lamp_o, mute_lamp_o, mix_lamp_o}, 5'h01);
  endtask : t_indep
  task automatic t_level();
    kn(8'h40);
    chk("level", line_level_o, 24'h000040);
    pr(1);
    chk("level", line_level_o, 24'h000040);
    kn(8'h80);
    chk("level", line_level_o, 24'h008040);
    user_u.set_host(1'b1, 1'b1);
    kn(8'h22);
    chk("level", line_level_o, 24'h222222);
    user_u.set_host(1'b0, 1'b0);
    tick(2);
    chk("line_en", line_en_o, 3'h2);
  endtask : t_level
  task automatic t_toggles();
    logic [2:0] eh [4];
    eh = '{3'h1, 3'h2, 3'h4, 3'h1};
    pr(4);
    chk("atten", {atten_on_o, atten_db_o, hp2_mix_o}, 9'h1A1);
    pr(4);
    chk("atten", atten_on_o, 1'b0);
    pr(7);
    chk("aux", {aux_to_mix1_o, aux_lamp_o}, 2'h3);
    pr(8);
    chk("phantom", phantom_on_o, 1'b1);
    pr(8);
    chk("phantom", phantom_on_o, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge ref_clk_i);
      hp2_mix_sel_i <= 2'(s);
      tick(2);
      chk("hp2_mix", hp2_mix_o, eh[s]);
    end
  endtask : t_toggles
  task automatic t_meter();
    @(posedge ref_clk_i);
    in_peak_a_i <= mpc_pkg::THR_M14;
    tick(2);
    chk("in_meter", in_meter_o, 4'h3);
    @(posedge ref_clk_i);
    in_peak_a_i <= mpc_pkg::THR_M48 - 16'h0001;
    tick(2);
    chk("in_meter", in_meter_o, 4'h0);
    @(posedge ref_clk_i);
    in_pair_sel_i <= 1'b1;
    in_peak_b_i <= mpc_pkg::THR_M3;
    in_clip_b_i <= 1'b1;
    out_peak_i <= {16'h0000, mpc_pkg::THR_M3, 16'h0000};
    tick(2);
    chk("in_meter", in_meter_o, 4'hF);
    chk("out_meter", out_meter_o, 4'h7);
    @(posedge ref_clk_i);
    out_peak_i <= {32'h0, mpc_pkg::THR_M3};
    out_clip_i <= 3'h1;
    in_clip_a_i <= 1'b1;
    tick(2);
    chk("out_meter", out_meter_o, 4'h0);
  endtask : t_meter
  task automatic t_clock();
    int tg;
    logic prev;
    tg = 0;
    @(posedge ref_clk_i);
    clk_src_spdif_i <= 1'b1;
    tick(3);
    prev = spdif_lamp_o;
    repeat (4 * FL)
    begin
      tick(1);
      tg += (spdif_lamp_o !== prev);
      prev = spdif_lamp_o;
    end
    chk("flash", {tg >= 3 && tg <= 5, int_lamp_o}, 2'h2);
    @(posedge ref_clk_i);
    clk_locked_i <= 1'b1;
    tick(FL + 3);
    chk("locked", spdif_lamp_o, 1'b1);
    @(posedge ref_clk_i);
    clk_src_spdif_i <= 1'b0;
    tick(3);
    chk("internal", {spdif_lamp_o, int_lamp_o}, 2'h1);
  endtask : t_clock
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    tick(2);
    t_start();
    t_alt();
    t_indep();
    t_level();
    t_toggles();
    t_meter();
    t_clock();
    user_u.press(9, DEB + POFF + 8);
    tick(2);
    chk("power", {power_on_o, power_lamp_dim_o, line_en_o}, 5'h08);
    end_sim();
  end
endmodule : tb
`default_nettype wire
